// File: rtl/mmbc_defines.svh
// Constants for the memory map and bus control block
`ifndef MMBC_DEFINES_SVH
`define MMBC_DEFINES_SVH

// ----------------------------------------
// Global map
// ----------------------------------------
`define MMBC_REG_BOT        18'h00000
`define MMBC_REG_TOP        18'h003FF
`define MMBC_RAM_END        18'h04000
`define MMBC_DFL_BOT        18'h04400
`define MMBC_DFL_TOP        18'h053FF
`define MMBC_PFL_END        19'h40000
`define MMBC_RAM_MAX        18'h02C00
`define MMBC_PFL_MAX        19'h38000
`define MMBC_NVM_PAGE       8'h01

// ----------------------------------------
// Local map and paging
// ----------------------------------------
`define MMBC_PAGE_RESET     8'h0E
`define MMBC_WIN_BOT        16'h8000
`define MMBC_WIN_TOP        16'hBFFF
`define MMBC_FIX_PAGE0      4'hC
`define MMBC_FIX_PAGE1      4'hD
`define MMBC_FIX_PAGE3      4'hF

// ----------------------------------------
// Arbitration
// ----------------------------------------
`define MMBC_DBG_STALL_MAX  128

`endif

// File: rtl/mmbc_pkg.sv
// Types for the memory map and bus control block
package mmbc_pkg;
	typedef enum logic [2:0] {
		MMBC_RGN_REG,
		MMBC_RGN_RAM,
		MMBC_RGN_DFL,
		MMBC_RGN_PFL,
		MMBC_RGN_NONE
	} mmbc_region_t;

	typedef enum logic [2:0] {
		MMBC_FAR_IDLE,
		MMBC_FAR_CALL_PUSH_RET,
		MMBC_FAR_CALL_PUSH_PAGE,
		MMBC_FAR_CALL_GO,
		MMBC_FAR_RET_PULL_ADDR,
		MMBC_FAR_RET_SET_PAGE,
		MMBC_FAR_RET_GO
	} mmbc_far_t;
endpackage

// File: rtl/mmbc_decode.sv
// Global address decoder: region classification and local-to-global mapping
`timescale 1ns/1ps
`default_nettype none
`include "mmbc_defines.svh"

module mmbc_decode #(
	parameter logic [17:0] RAM_SIZE   = 18'h02C00,
	parameter logic [18:0] FLASH_SIZE = 19'h38000
) (
	input  wire logic [15:0]          localAddr,
	input  wire logic [7:0]           pageIndex,
	output logic [17:0]               globalAddr,
	output mmbc_pkg::mmbc_region_t    region
);
	import mmbc_pkg::*;

	logic [17:0] ramLow;
	logic [18:0] pflLow;

	// ----------------------------------------
	// Bottoms from implemented sizes
	// ----------------------------------------
	assign ramLow = `MMBC_RAM_END - RAM_SIZE;
	assign pflLow = `MMBC_PFL_END - FLASH_SIZE;

	// Local window translation; fixed 16 kB quarters map to fixed pages
	always_comb begin
		unique case (localAddr[15:14])
			2'b00:   globalAddr = {`MMBC_FIX_PAGE0, localAddr[13:0]};
			2'b01:   globalAddr = {`MMBC_FIX_PAGE1, localAddr[13:0]};
			2'b10:   globalAddr = {pageIndex[3:0], localAddr[13:0]};
			default: globalAddr = {`MMBC_FIX_PAGE3, localAddr[13:0]};
		endcase
	end

	// Region classification; registers win over the overlapping RAM range
	always_comb begin
		if (globalAddr <= `MMBC_REG_TOP)
			region = MMBC_RGN_REG;
		else if (globalAddr >= ramLow && globalAddr < `MMBC_RAM_END)
			region = MMBC_RGN_RAM;
		else if (globalAddr >= `MMBC_DFL_BOT && globalAddr <= `MMBC_DFL_TOP)
			region = MMBC_RGN_DFL;
		else if ({1'b0, globalAddr} >= pflLow)
			region = MMBC_RGN_PFL;
		else
			region = MMBC_RGN_NONE;
	end
endmodule
`default_nettype wire

// File: rtl/mmbc_top.sv
// Memory map, arbitration, byte swap and far call paging for the MCU core
// What this block does
// - Registers at global 0x0_0000..0x0_03FF.
// - RAM up to 11 kB ending 0x0_3FFF.
// - RAM bottom is 0x0_4000 minus size.
// - Data flash at 0x0_4400..0x0_53FF.
// - Program flash top 0x3_FFFF, size-based bottom.
// - Info rows plus data flash: page 0x01.
// - CPU unimplemented access resets in single-chip mode only, firmware exempt.
// - Debug master unimplemented access never resets.
// - Swap CPU read byte lanes here.
// - One master per target bus.
// - CPU wins contention by default.
// - Debug stalled over 128 cycles wins.
// - No interrupt requests generated.
// - Far call saves page, then loads new.
// - Far call pushes return, old page, jumps.
// - Far sequences are uninterruptible.
// - New page immediate or fetched indirectly.
// - Far return pulls page, address, writes page.
// - Page selects 16 kB window page.
// - Page register resets to 0x0E.
// - Window 0x8000..0xBFFF translated by page.
`timescale 1ns/1ps
`default_nettype none
`include "mmbc_defines.svh"

module mmbc_top #(
	parameter logic [17:0] RAM_SIZE   = 18'h02C00,
	parameter logic [18:0] FLASH_SIZE = 19'h38000,
	parameter int          STALL_MAX  = `MMBC_DBG_STALL_MAX
) (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        singleChip,
	// CPU master
	input  wire logic        cpuReq,
	input  wire logic [15:0] cpuAddr,
	input  wire logic        cpuWrite,
	input  wire logic        cpuWord,
	input  wire logic        cpuFirmware,
	input  wire logic        cpuOpDone,
	output logic             cpuGrant,
	output logic [15:0]      cpuRdata,
	// Far call / return sequencer
	input  wire logic        farCallStart,
	input  wire logic        farRetStart,
	input  wire logic [7:0]  farNewPage,
	input  wire logic        farStep,
	output logic [7:0]       farPushData,
	output logic             farBusy,
	output logic             irqInhibit,
	// Software write to page register
	input  wire logic        pageWrite,
	input  wire logic [7:0]  pageWdata,
	output logic [7:0]       program_page_index,
	// Debug master
	input  wire logic        background_debug_master_req,
	input  wire logic [15:0] dbgAddr,
	output logic             dbgGrant,
	// Target bus zero
	input  wire logic [15:0] tgtRdata,
	output logic [17:0]      target_bus_zero_addr,
	output logic             target_bus_zero_write,
	output logic             target_bus_zero_sel,
	output mmbc_pkg::mmbc_region_t target_bus_zero_region,
	output logic             illegalReset,
	output logic             interruptReq
);
	import mmbc_pkg::*;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic [17:0]  cpuGlobal;
	logic [17:0]  dbgGlobal;
	mmbc_region_t cpuRegion;
	mmbc_region_t dbgRegion;
	logic [7:0]   pageReg;

	mmbc_decode #(.RAM_SIZE(RAM_SIZE), .FLASH_SIZE(FLASH_SIZE)) uCpuDec (
		.localAddr (cpuAddr),
		.pageIndex (pageReg),
		.globalAddr(cpuGlobal),
		.region    (cpuRegion)
	);

	// Debug master uses the same paging scheme as the CPU
	mmbc_decode #(.RAM_SIZE(RAM_SIZE), .FLASH_SIZE(FLASH_SIZE)) uDbgDec (
		.localAddr (dbgAddr),
		.pageIndex (pageReg),
		.globalAddr(dbgGlobal),
		.region    (dbgRegion)
	);

	// ----------------------------------------
	// Arbitration state
	// ----------------------------------------
	logic       cpuGrant_reg, cpuGrant_next;
	logic       dbgGrant_reg, dbgGrant_next;
	logic       dbgPrio_reg,  dbgPrio_next;
	logic [7:0] stallCnt_reg, stallCnt_next;
	logic       stallHit;

	assign stallHit = (32'(stallCnt_reg) >= STALL_MAX);

	// CPU first; a debug access starved past the limit takes the bus once CPU op ends
	always_comb begin
		stallCnt_next = stallCnt_reg;
		dbgPrio_next  = dbgPrio_reg;
		if (!background_debug_master_req || dbgGrant_reg) begin
			stallCnt_next = 8'h00;
			dbgPrio_next  = 1'b0;
		end else if (stallHit) begin
			dbgPrio_next  = 1'b1;
		end else begin
			stallCnt_next = stallCnt_reg + 8'h01;
		end
		// Hold the CPU until its current operation completes
		if (dbgPrio_reg && (!cpuGrant_reg || cpuOpDone || !cpuReq)) begin
			dbgGrant_next = background_debug_master_req;
			cpuGrant_next = 1'b0;
		end else if (dbgPrio_reg) begin
			dbgGrant_next = 1'b0;
			cpuGrant_next = cpuGrant_reg;
		end else if (cpuReq) begin
			cpuGrant_next = 1'b1;
			dbgGrant_next = 1'b0;
		end else begin
			cpuGrant_next = 1'b0;
			dbgGrant_next = background_debug_master_req;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cpuGrant_reg <= 1'b0;
			dbgGrant_reg <= 1'b0;
			dbgPrio_reg  <= 1'b0;
			stallCnt_reg <= 8'h00;
		end else begin
			cpuGrant_reg <= cpuGrant_next;
			dbgGrant_reg <= dbgGrant_next;
			dbgPrio_reg  <= dbgPrio_next;
			stallCnt_reg <= stallCnt_next;
		end
	end

	// ----------------------------------------
	// Target bus, illegal access, read swap
	// ----------------------------------------
	logic [17:0]  tAddr_reg, tAddr_next;
	logic         tWr_reg, tWr_next;
	logic         tSel_reg, tSel_next;
	mmbc_region_t tRgn_reg, tRgn_next;
	logic         illegal_reg, illegal_next;
	logic [15:0]  rdata_reg, rdata_next;

	// Mux the granted master; debug misaligned words are blocked upstream
	always_comb begin
		tAddr_next   = tAddr_reg;
		tWr_next     = 1'b0;
		tSel_next    = 1'b0;
		tRgn_next    = tRgn_reg;
		illegal_next = 1'b0;
		rdata_next   = rdata_reg;
		if (cpuGrant_next && cpuReq) begin
			tAddr_next = cpuGlobal;
			tWr_next   = cpuWrite;
			tSel_next  = 1'b1;
			tRgn_next  = cpuRegion;
			// Firmware commands are exempt from the illegal access reset
			illegal_next = singleChip && !cpuFirmware && (cpuRegion == MMBC_RGN_NONE);
		end else if (dbgGrant_next) begin
			tAddr_next = dbgGlobal;
			tSel_next  = 1'b1;
			tRgn_next  = dbgRegion;
		end
		// Odd byte reads land on the low lane for the CPU
		if (cpuGrant_reg && !tWr_reg)
			rdata_next = (!cpuWord && tAddr_reg[0]) ? {8'h00, tgtRdata[7:0]}
			           : (!cpuWord) ? {8'h00, tgtRdata[15:8]} : tgtRdata;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			tAddr_reg   <= 18'h00000;
			tWr_reg     <= 1'b0;
			tSel_reg    <= 1'b0;
			tRgn_reg    <= MMBC_RGN_REG;
			illegal_reg <= 1'b0;
			rdata_reg   <= 16'h0000;
		end else begin
			tAddr_reg   <= tAddr_next;
			tWr_reg     <= tWr_next;
			tSel_reg    <= tSel_next;
			tRgn_reg    <= tRgn_next;
			illegal_reg <= illegal_next;
			rdata_reg   <= rdata_next;
		end
	end

	// ----------------------------------------
	// Page register and far sequencer
	// ----------------------------------------
	mmbc_far_t  far_reg, far_next;
	logic [7:0] saved_reg, saved_next;
	logic [7:0] page_next;
	logic [7:0] push_reg, push_next;

	// New page comes from operand or indirect fetch, both on farNewPage
	always_comb begin
		far_next   = far_reg;
		saved_next = saved_reg;
		page_next  = pageReg;
		push_next  = push_reg;
		unique case (far_reg)
			MMBC_FAR_IDLE: begin
				if (farCallStart) begin
					saved_next = pageReg;
					page_next  = farNewPage;
					far_next   = MMBC_FAR_CALL_PUSH_RET;
				end else if (farRetStart) begin
					saved_next = farNewPage;
					far_next   = MMBC_FAR_RET_PULL_ADDR;
				end else if (pageWrite) begin
					page_next  = pageWdata;
				end
			end
			MMBC_FAR_CALL_PUSH_RET: if (farStep) begin
				push_next = saved_reg;
				far_next  = MMBC_FAR_CALL_PUSH_PAGE;
			end
			MMBC_FAR_CALL_PUSH_PAGE: if (farStep) far_next = MMBC_FAR_CALL_GO;
			MMBC_FAR_CALL_GO:        if (farStep) far_next = MMBC_FAR_IDLE;
			MMBC_FAR_RET_PULL_ADDR:  if (farStep) far_next = MMBC_FAR_RET_SET_PAGE;
			MMBC_FAR_RET_SET_PAGE: if (farStep) begin
				page_next = saved_reg;
				far_next  = MMBC_FAR_RET_GO;
			end
			MMBC_FAR_RET_GO: if (farStep) far_next = MMBC_FAR_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			far_reg   <= MMBC_FAR_IDLE;
			saved_reg <= 8'h00;
			pageReg   <= `MMBC_PAGE_RESET;
			push_reg  <= 8'h00;
		end else begin
			far_reg   <= far_next;
			saved_reg <= saved_next;
			pageReg   <= page_next;
			push_reg  <= push_next;
		end
	end

	// ----------------------------------------
	// Outputs, all flip-flops except interruptReq, tied to zero
	// ----------------------------------------
	logic busy_reg;
	always_ff @(posedge core_clk) begin
		if (!nrst)
			busy_reg <= 1'b0;
		else
			busy_reg <= (far_next != MMBC_FAR_IDLE);
	end

	assign cpuGrant               = cpuGrant_reg;
	assign dbgGrant               = dbgGrant_reg;
	assign cpuRdata               = rdata_reg;
	assign farPushData            = push_reg;
	assign farBusy                = busy_reg;
	assign irqInhibit             = busy_reg;
	assign program_page_index     = pageReg;
	assign target_bus_zero_addr   = tAddr_reg;
	assign target_bus_zero_write  = tWr_reg;
	assign target_bus_zero_sel    = tSel_reg;
	assign target_bus_zero_region = tRgn_reg;
	assign illegalReset           = illegal_reg;
	assign interruptReq           = 1'b0;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_ONE_MASTER: assert property (@(posedge core_clk) disable iff (!nrst)
		!(cpuGrant && dbgGrant)) else $error("both masters granted");
	AST_CPU_FIRST: assert property (@(posedge core_clk) disable iff (!nrst)
		(cpuReq && background_debug_master_req && !dbgPrio_reg) |=> !dbgGrant)
		else $error("debug won without timeout");
	AST_STALL_FLIP: assert property (@(posedge core_clk) disable iff (!nrst)
		(stallHit && background_debug_master_req && !dbgGrant) |=> dbgPrio_reg)
		else $error("timeout did not raise debug priority");
	AST_CNT_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
		!background_debug_master_req |=> stallCnt_reg == 8'h00) else $error("stall count kept");
	AST_ILLEGAL: assert property (@(posedge core_clk) disable iff (!nrst)
		(cpuGrant_next && cpuReq && singleChip && !cpuFirmware && cpuRegion == MMBC_RGN_NONE)
		|=> illegalReset) else $error("missing illegal reset");
	AST_DBG_NORESET: assert property (@(posedge core_clk) disable iff (!nrst)
		(dbgGrant_next && !(cpuGrant_next && cpuReq)) |=> !illegalReset)
		else $error("debug access reset");
	AST_CALL_PAGE: assert property (@(posedge core_clk) disable iff (!nrst)
		(far_reg == MMBC_FAR_IDLE && farCallStart) |=> program_page_index == $past(farNewPage)
		&& saved_reg == $past(pageReg)) else $error("far call page swap wrong");
	AST_RET_PAGE: assert property (@(posedge core_clk) disable iff (!nrst)
		(far_reg == MMBC_FAR_RET_SET_PAGE && farStep) |=> program_page_index == $past(saved_reg))
		else $error("far return page wrong");
	AST_NO_IRQ: assert property (@(posedge core_clk) disable iff (!nrst)
		!interruptReq) else $error("interrupt raised");
	COV_STALL: cover property (@(posedge core_clk) disable iff (!nrst) $rose(dbgPrio_reg));
	COV_CALL: cover property (@(posedge core_clk) disable iff (!nrst) far_reg == MMBC_FAR_CALL_GO);
	COV_RET: cover property (@(posedge core_clk) disable iff (!nrst) far_reg == MMBC_FAR_RET_GO);
	COV_ILLEGAL: cover property (@(posedge core_clk) disable iff (!nrst) illegalReset);
endmodule
`default_nettype wire

// File: verif/mmbc_dbg_master.sv
// Debug master model for the arbitration port of the bus control block
`timescale 1ns/1ps
`default_nettype none

module mmbc_dbg_master (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        start,
	input  wire logic [15:0] startAddr,
	input  wire logic        dbgGrant,
	output logic             background_debug_master_req,
	output logic [15:0]      dbgAddr
);
	// -----------------------------------------
	// Request handshake
	// -----------------------------------------
	// Hold until grant seen on an edge; byte requests only, never a misaligned word
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			background_debug_master_req <= 1'b0;
			dbgAddr                     <= 16'h5A5A;
		end else if (background_debug_master_req && dbgGrant) begin
			background_debug_master_req <= 1'b0;
			dbgAddr                     <= ~dbgAddr; // Released bus must not look valid
		end else if (start && !background_debug_master_req) begin
			background_debug_master_req <= 1'b1;
			dbgAddr                     <= startAddr;
		end
	end
endmodule

`default_nettype wire

// File: verif/memory_map_bus_control_tb.sv
// Self-checking bench for the memory map and bus control block
`timescale 1ns/1ps
`default_nettype none

module memory_map_bus_control_tb;
	import mmbc_pkg::*;
	localparam logic [18:0] FL_SZ = 19'h20000;
	localparam int          STALL = 8;

	logic         core_clk, nrst, singleChip, cpuReq, cpuWrite, cpuWord, cpuFirmware, cpuOpDone;
	logic         farCallStart, farRetStart, farStep, pageWrite, dbgStart, dbgReq, cpuGrant, dbgGrant;
	logic         farBusy, irqInhibit, busWrite, busSel, illegalReset, interruptReq;
	logic [7:0]   farNewPage, pageWdata, farPushData, pageIdx, curPage, pa, pb;
	logic [15:0]  cpuAddr, dbgAddr, dbgStartAddr, tgtRdata, cpuRdata;
	logic [17:0]  busAddr;
	mmbc_region_t busRegion;
	logic [31:0]  seed;
	int           miscompares, numChecks, i, k;
	logic [7:0]   cPage [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h07, 8'h08};
	logic [13:0]  cOff  [8] = '{14'h0000, 14'h03FF, 14'h2800, 14'h3FFF, 14'h0400, 14'h13FF, 14'h3FFF, 14'h0000};

	mmbc_top #(.RAM_SIZE(18'h01800), .FLASH_SIZE(FL_SZ), .STALL_MAX(STALL)) u_mmbc_top (
		.core_clk(core_clk), .nrst(nrst), .singleChip(singleChip), .cpuReq(cpuReq), .cpuAddr(cpuAddr),
		.cpuWrite(cpuWrite), .cpuWord(cpuWord), .cpuFirmware(cpuFirmware), .cpuOpDone(cpuOpDone),
		.cpuGrant(cpuGrant), .cpuRdata(cpuRdata), .farCallStart(farCallStart), .farRetStart(farRetStart),
		.farNewPage(farNewPage), .farStep(farStep), .farPushData(farPushData), .farBusy(farBusy),
		.irqInhibit(irqInhibit), .pageWrite(pageWrite), .pageWdata(pageWdata), .program_page_index(pageIdx),
		.background_debug_master_req(dbgReq), .dbgAddr(dbgAddr), .dbgGrant(dbgGrant), .tgtRdata(tgtRdata),
		.target_bus_zero_addr(busAddr), .target_bus_zero_write(busWrite), .target_bus_zero_sel(busSel),
		.target_bus_zero_region(busRegion), .illegalReset(illegalReset), .interruptReq(interruptReq));

	mmbc_dbg_master u_mmbc_dbg_master (.core_clk(core_clk), .nrst(nrst), .start(dbgStart),
		.startAddr(dbgStartAddr), .dbgGrant(dbgGrant), .background_debug_master_req(dbgReq), .dbgAddr(dbgAddr));

	// -----------------------------------------
	// Helpers
	// -----------------------------------------
	function automatic logic [31:0] nextRand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Window uses the low page bits; the top local block is page 0xF
	function automatic logic [17:0] expGlobal(input logic [15:0] a, input logic [7:0] p);
		return (a[15:14] == 2'b10) ? {p[3:0], a[13:0]} : {4'hF, a[13:0]};
	endfunction

	function automatic mmbc_region_t expRegion(input logic [17:0] g);
		if (g <= 18'h003FF) return MMBC_RGN_REG;
		if (g >= 18'h02800 && g <= 18'h03FFF) return MMBC_RGN_RAM;
		if (g >= 18'h04400 && g <= 18'h053FF) return MMBC_RGN_DFL;
		if ({1'b0, g} >= 19'h40000 - FL_SZ) return MMBC_RGN_PFL;
		return MMBC_RGN_NONE;
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Bounded wait for a grant; a hang ends the run
	task automatic waitHigh(input logic dbg);
		for (k = 0; k < 32 && (dbg ? dbgGrant : cpuGrant) !== 1'b1; k++) tick(1);
		if ((dbg ? dbgGrant : cpuGrant) !== 1'b1) begin
			miscompares++;
			$display("unexpected grant wait expired");
			complete_run();
		end
	endtask

	task automatic setPage(input logic [7:0] p);
		pageWrite = 1'b1;
		pageWdata = p;
		tick(1);
		pageWrite = 1'b0;
		curPage   = p;
		check("page write", pageIdx, p);
	endtask

	task automatic step();
		farStep = 1'b1;
		tick(1);
		farStep = 1'b0;
		tick(1);
	endtask

	task automatic cpuAccess(input logic [15:0] a, input logic wr, input logic word, input logic fw);
		logic [17:0] g;
		logic [15:0] d;
		g           = expGlobal(a, curPage);
		d           = 16'(nextRand());
		tgtRdata    = d;
		cpuAddr     = a;
		cpuWrite    = wr;
		cpuWord     = word;
		cpuFirmware = fw;
		cpuReq      = 1'b1;
		waitHigh(1'b0);
		check("addr", busAddr, g);
		check("region", busRegion, expRegion(g));
		check("sel write", {busSel, busWrite}, {1'b1, wr});
		check("illegal", illegalReset, singleChip && !fw && expRegion(g) == MMBC_RGN_NONE);
		tick(1);
		if (!wr) check("rdata", cpuRdata, word ? d : {8'h00, a[0] ? d[7:0] : d[15:8]});
		cpuReq = 1'b0;
		tick(1);
	endtask

	// -----------------------------------------
	// Clock, watchdog and bus monitor
	// -----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	initial begin
		#2000000;
		miscompares++;
		$display("unexpected run length exceeded");
		complete_run();
	end

	// Exclusive ownership and silent interrupt line every cycle out of reset
	always @(negedge core_clk) begin
		if (nrst === 1'b1) begin
			check("grant overlap", cpuGrant & dbgGrant, 0);
			check("irq", interruptReq, 0);
		end
	end

	// -----------------------------------------
	// Main sequence
	// -----------------------------------------
	initial begin
		{nrst, singleChip, cpuReq, cpuWrite, cpuWord, cpuFirmware, cpuOpDone} = '0;
		{farCallStart, farRetStart, farStep, pageWrite, dbgStart} = '0;
		{farNewPage, pageWdata, cpuAddr, dbgStartAddr, tgtRdata} = '0;
		seed        = 32'h4BD8EC5F;
		miscompares = 0;
		numChecks   = 0;
		curPage     = 8'h0E;
		tick(2);
		nrst = 1'b1;
		tick(1);
		check("page reset", pageIdx, 8'h0E);
		singleChip = 1'b1;
		for (i = 0; i < 8; i++) begin
			setPage(cPage[i]);
			cpuAccess({2'b10, cOff[i]}, 1'b0, 1'b0, 1'b0);
		end
		cpuAccess(16'hC123, 1'b0, 1'b1, 1'b0);
		setPage(8'h05);
		cpuAccess(16'h8100, 1'b0, 1'b0, 1'b1); // Firmware exempt
		singleChip = 1'b0;
		cpuAccess(16'h8100, 1'b0, 1'b0, 1'b0); // Normal mode exempt
		for (i = 0; i < 40; i++) begin
			singleChip = nextRand() % 2;
			setPage(8'(2 + nextRand() % 14));
			pa = 8'(nextRand());
			cpuAccess({2'b10, 14'(nextRand())} & {15'h7FFF, ~pa[0]}, pa[1], pa[0], pa[2]);
		end
		// Debug master into a hole with the CPU idle
		singleChip   = 1'b1;
		setPage(8'h04);
		dbgStartAddr = 16'h8000;
		dbgStart     = 1'b1;
		tick(1);
		dbgStart = 1'b0;
		waitHigh(1'b1);
		check("debug no reset", illegalReset, 0);
		tick(2);
		// CPU holds the bus; debug wins only after the stall limit and an op end
		cpuAddr = 16'h8010;
		cpuReq  = 1'b1;
		waitHigh(1'b0);
		for (i = 0; i < 2; i++) begin
			dbgStart = 1'b1;
			tick(1);
			dbgStart  = 1'b0;
			cpuOpDone = 1'b1;
			tick(1);
			cpuOpDone = 1'b0;
			for (k = 0; k < STALL + 2; k++) begin
				check("debug early", dbgGrant, 0);
				tick(1);
			end
			cpuOpDone = 1'b1;
			tick(1);
			cpuOpDone = 1'b0;
			waitHigh(1'b1);
			check("cpu stalled", cpuGrant, 0);
			waitHigh(1'b0);
		end
		cpuReq = 1'b0;
		tick(2);
		// Far call then far return with random pages
		for (i = 0; i < 3; i++) begin
			pa = 8'(nextRand());
			pb = 8'(nextRand());
			setPage(pa);
			farNewPage   = pb;
			farCallStart = 1'b1;
			tick(1);
			farCallStart = 1'b0;
			check("call page", pageIdx, pb);
			check("call busy", {farBusy, irqInhibit}, 2'b11);
			step();
			check("push page", farPushData, pa);
			step();
			step();
			tick(1);
			check("call done", {farBusy, irqInhibit}, 2'b00);
			farNewPage  = pa;
			farRetStart = 1'b1;
			tick(1);
			farRetStart = 1'b0;
			check("ret busy", {farBusy, irqInhibit}, 2'b11);
			step();
			check("ret early page", pageIdx, pb);
			step();
			check("ret page", pageIdx, pa);
			step();
			tick(1);
			check("ret done", farBusy, 0);
		end
		nrst = 1'b0;
		tick(1);
		nrst = 1'b1;
		tick(1);
		check("page rereset", pageIdx, 8'h0E);
		complete_run();
	end
endmodule

`default_nettype wire
